//--- ysu_pkg.sv
`default_nettype none
package ysu_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Packed 4:2:2 byte orders
   typedef enum logic [1:0]
   {
      packed_order_normal = 2'h0,
      packed_order_chroma_swapped = 2'h1,
      packed_order_luma_swapped = 2'h2,
      packed_order_both_swapped = 2'h3
   } ysu_order_t;

   // Planar layouts
   typedef enum logic [1:0]
   {
      planar_independent = 2'h0,
      contiguous_planar_420 = 2'h1,
      contiguous_planar_410 = 2'h2,
      planar_reserved = 2'h3
   } ysu_planar_t;

   ////////////////////////////////////////////////////////////////////////////
   // Field geometry
   localparam int COMP_W = 8;
   localparam int WORD_W = 32;
   localparam int LANE0_LSB = 0;
   localparam int LANE1_LSB = 8;
   localparam int LANE2_LSB = 16;
   localparam int LANE3_LSB = 24;
   localparam int FIFO_DEPTH = 32;
   localparam int FIFO_W = WORD_W + 2;

   // Chroma stride and row shifts per layout
   localparam int SHIFT_420 = 1;
   localparam int SHIFT_410 = 2;

   ////////////////////////////////////////////////////////////////////////////
   // Values after reset
   localparam logic [7:0] COMP_RESET = 8'h00;
   localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
   localparam logic [15:0] STRIDE_RESET = 16'h0000;

endpackage : ysu_pkg
`default_nettype wire

//--- ysu_sink.sv
`timescale 1ns/1ps
`default_nettype none
// Sampler side: takes pixels, stalls on command
module ysu_sink
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic stall,
   input wire logic slow,
   input wire logic out_valid,
   output var logic out_ready,
   input wire logic [7:0] out_y,
   input wire logic [7:0] out_u,
   input wire logic [7:0] out_v,
   input wire logic out_second
);
   logic [24:0] got[$];
   logic tog = 1'b0;
   initial out_ready = 1'b0;
   always @(posedge clock)
   begin
      if (out_valid === 1'b1 && out_ready === 1'b1)
         got.push_back({out_second, out_y, out_u, out_v});
      tog <= ~tog;
      out_ready <= #1 rst_n && !stall && !(slow && tog);
   end
endmodule : ysu_sink
`default_nettype wire

//--- ysu_unpacker.sv
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Word buffer between the memory read path and the unpacker
module ysu_fifo #(
   parameter int WIDTH = 34,
   parameter int DEPTH = 32
)
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic wr_valid,
   output logic wr_ready,
   input wire logic [WIDTH-1:0] wr_data,
   output logic rd_valid,
   input wire logic rd_ready,
   output logic [WIDTH-1:0] rd_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_r;
   logic [AW-1:0] rd_ptr_r;
   logic [AW:0] count_r;
   logic [AW:0] count_nxt;
   logic wr_ready_r;
   logic push;
   logic pop;

   assign push = wr_valid && wr_ready_r;
   assign pop = rd_ready && (count_r != '0);
   assign count_nxt = count_r + (AW+1)'(push) - (AW+1)'(pop);
   // Registered ready, low during reset
   assign wr_ready = wr_ready_r;
   assign rd_valid = (count_r != '0);
   assign rd_data = mem[rd_ptr_r];

   always_ff @(posedge clock)
   begin
      if (push)
      begin
         mem[wr_ptr_r] <= wr_data;
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
         wr_ready_r <= 1'b0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
         end
         if (pop)
         begin
            rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
         end
         count_r <= count_nxt;
         wr_ready_r <= (count_nxt != (AW+1)'(DEPTH));
      end
   end
endmodule : ysu_fifo

////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Each Y, U, V component is an unsigned byte
// - One 32-bit word yields two adjacent pixels
// - Four byte orders chosen by format code
// - Normal Y0 U Y1 V; chroma swap exchanges U/V
// - Luma swap U Y0 V Y1; both V Y0 U Y1
// - Red takes V, green Y, blue U
// - Luma stride separate from shared chroma stride
// - Contiguous 4:2:0 chroma stride is half luma
// - Contiguous 4:1:0 chroma stride is quarter luma
module ysu_unpacker #(
   parameter int WORD_W = ysu_pkg::WORD_W,
   parameter int DEPTH = ysu_pkg::FIFO_DEPTH,
   parameter int ADDR_W = 32,
   parameter int STRIDE_W = 16
)
(
   input wire logic clock,
   input wire logic rst_n,
   // Packed word stream from memory
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WORD_W-1:0] in_data,
   input wire logic [1:0] in_order,
   // Pixel stream to the sampler
   output logic out_valid,
   input wire logic out_ready,
   output logic [7:0] out_y,
   output logic [7:0] out_u,
   output logic [7:0] out_v,
   output logic [7:0] out_red,
   output logic [7:0] out_green,
   output logic [7:0] out_blue,
   output logic out_second,
   // Planar surface description
   input wire logic [1:0] planar_layout,
   input wire logic [ADDR_W-1:0] luma_base,
   input wire logic [STRIDE_W-1:0] luma_stride,
   input wire logic [STRIDE_W-1:0] luma_rows,
   input wire logic [STRIDE_W-1:0] chroma_stride_in,
   input wire logic [ADDR_W-1:0] u_base_in,
   input wire logic [ADDR_W-1:0] v_base_in,
   output logic [ADDR_W-1:0] luma_base_out,
   output logic [STRIDE_W-1:0] luma_stride_out,
   output logic [STRIDE_W-1:0] chroma_stride_out,
   output logic [ADDR_W-1:0] u_base_out,
   output logic [ADDR_W-1:0] v_base_out,
   output logic planar_error
);
   typedef enum logic {UNP_FIRST, UNP_SECOND} ysu_state_t;

   ////////////////////////////////////////////////////////////////////////////
   // Buffer
   logic fifo_wr_ready;
   logic fifo_rd_valid;
   logic fifo_rd_ready;
   logic [WORD_W+1:0] fifo_rd_data;

   ysu_fifo #(
      .WIDTH(WORD_W + 2),
      .DEPTH(DEPTH)
   ) u_fifo (
      .clock(clock),
      .rst_n(rst_n),
      .wr_valid(in_valid),
      .wr_ready(fifo_wr_ready),
      .wr_data({in_order, in_data}),
      .rd_valid(fifo_rd_valid),
      .rd_ready(fifo_rd_ready),
      .rd_data(fifo_rd_data)
   );

   // Ready comes straight from the buffer's flop
   assign in_ready = fifo_wr_ready;

   ////////////////////////////////////////////////////////////////////////////
   // Byte lane decode
   logic [WORD_W-1:0] word;
   ysu_pkg::ysu_order_t order;
   logic [7:0] lane [4];
   logic [7:0] dec_y0;
   logic [7:0] dec_y1;
   logic [7:0] dec_u;
   logic [7:0] dec_v;
   logic luma_high;
   logic chroma_flip;

   assign word = fifo_rd_data[WORD_W-1:0];
   assign order = ysu_pkg::ysu_order_t'(fifo_rd_data[WORD_W+1:WORD_W]);

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++)
      begin : g_lane
         assign lane[gi] = word[gi*ysu_pkg::COMP_W +: ysu_pkg::COMP_W];
      end
   endgenerate

   // Luma in lanes 1 and 3 for the two luma-swapped orders
   assign luma_high = (order == ysu_pkg::packed_order_luma_swapped) ||
                      (order == ysu_pkg::packed_order_both_swapped);
   // V before U in the low chroma lane
   assign chroma_flip = (order == ysu_pkg::packed_order_chroma_swapped) ||
                        (order == ysu_pkg::packed_order_both_swapped);

   assign dec_y0 = luma_high ? lane[1] : lane[0];
   assign dec_y1 = luma_high ? lane[3] : lane[2];
   assign dec_u = luma_high ? (chroma_flip ? lane[2] : lane[0])
                            : (chroma_flip ? lane[3] : lane[1]);
   assign dec_v = luma_high ? (chroma_flip ? lane[0] : lane[2])
                            : (chroma_flip ? lane[1] : lane[3]);

   ////////////////////////////////////////////////////////////////////////////
   // Pixel serialiser
   ysu_state_t state_r;
   ysu_state_t state_nxt;
   logic load;
   logic take;
   logic [7:0] pix_y;
   logic out_valid_r;
   logic out_second_r;
   logic [7:0] y_r;
   logic [7:0] u_r;
   logic [7:0] v_r;

   assign load = !out_valid_r || out_ready;
   assign take = load && fifo_rd_valid;
   assign pix_y = (state_r == UNP_SECOND) ? dec_y1 : dec_y0;
   // Word leaves the buffer only after its second pixel
   assign fifo_rd_ready = take && (state_r == UNP_SECOND);

   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         UNP_FIRST:
         begin
            if (take)
            begin
               state_nxt = UNP_SECOND;
            end
         end
         UNP_SECOND:
         begin
            if (take)
            begin
               state_nxt = UNP_FIRST;
            end
         end
         default:
         begin
            state_nxt = UNP_FIRST;
         end
      endcase
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_r <= UNP_FIRST;
         out_valid_r <= 1'b0;
         out_second_r <= 1'b0;
         y_r <= ysu_pkg::COMP_RESET;
         u_r <= ysu_pkg::COMP_RESET;
         v_r <= ysu_pkg::COMP_RESET;
      end
      else
      begin
         state_r <= state_nxt;
         if (load)
         begin
            out_valid_r <= fifo_rd_valid;
         end
         if (take)
         begin
            out_second_r <= (state_r == UNP_SECOND);
            y_r <= pix_y;
            u_r <= dec_u;
            v_r <= dec_v;
         end
      end
   end

   assign out_valid = out_valid_r;
   assign out_second = out_second_r;
   assign out_y = y_r;
   assign out_u = u_r;
   assign out_v = v_r;
   assign out_red = v_r;
   assign out_green = y_r;
   assign out_blue = u_r;

   ////////////////////////////////////////////////////////////////////////////
   // Planar strides and plane bases
   ysu_pkg::ysu_planar_t layout;
   logic is_contig;
   logic [1:0] cshift;
   logic [STRIDE_W-1:0] c_stride;
   logic [STRIDE_W-1:0] c_rows;
   logic [ADDR_W-1:0] luma_size;
   logic [ADDR_W-1:0] chroma_size;
   logic [ADDR_W-1:0] u_base_nxt;
   logic [ADDR_W-1:0] v_base_nxt;
   logic [ADDR_W-1:0] luma_base_r;
   logic [STRIDE_W-1:0] luma_stride_r;
   logic [STRIDE_W-1:0] chroma_stride_r;
   logic [ADDR_W-1:0] u_base_r;
   logic [ADDR_W-1:0] v_base_r;
   logic planar_error_r;

   assign layout = ysu_pkg::ysu_planar_t'(planar_layout);
   assign is_contig = (layout == ysu_pkg::contiguous_planar_420) ||
                      (layout == ysu_pkg::contiguous_planar_410);
   assign cshift = (layout == ysu_pkg::contiguous_planar_410) ?
                   2'(ysu_pkg::SHIFT_410) : 2'(ysu_pkg::SHIFT_420);
   // Chroma stride is derived only for contiguous layouts
   assign c_stride = is_contig ? (luma_stride >> cshift) : chroma_stride_in;
   assign c_rows = luma_rows >> cshift;
   assign luma_size = ADDR_W'(luma_stride) * ADDR_W'(luma_rows);
   assign chroma_size = ADDR_W'(c_stride) * ADDR_W'(c_rows);
   // In contiguous layouts planes follow one another: Y, then U, then V
   assign u_base_nxt = is_contig ? ADDR_W'(luma_base + luma_size) : u_base_in;
   assign v_base_nxt = is_contig ? ADDR_W'(u_base_nxt + chroma_size) : v_base_in;

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         luma_base_r <= ysu_pkg::ADDR_RESET;
         luma_stride_r <= ysu_pkg::STRIDE_RESET;
         chroma_stride_r <= ysu_pkg::STRIDE_RESET;
         u_base_r <= ysu_pkg::ADDR_RESET;
         v_base_r <= ysu_pkg::ADDR_RESET;
         planar_error_r <= 1'b0;
      end
      else
      begin
         luma_base_r <= luma_base;
         luma_stride_r <= luma_stride;
         chroma_stride_r <= c_stride;
         u_base_r <= u_base_nxt;
         v_base_r <= v_base_nxt;
         planar_error_r <= (layout == ysu_pkg::planar_reserved);
      end
   end

   assign luma_base_out = luma_base_r;
   assign luma_stride_out = luma_stride_r;
   assign chroma_stride_out = chroma_stride_r;
   assign u_base_out = u_base_r;
   assign v_base_out = v_base_r;
   assign planar_error = planar_error_r;

endmodule : ysu_unpacker
`default_nettype wire

//--- ysu_unpacker_chk.sv
`timescale 1ns/1ps
`default_nettype none
module ysu_unpacker_chk #(
   parameter int ADDR_W = 32,
   parameter int STRIDE_W = 16
)
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic in_valid,
   input wire logic in_ready,
   input wire logic out_valid,
   input wire logic out_ready,
   input wire logic [7:0] out_y,
   input wire logic [7:0] out_u,
   input wire logic [7:0] out_v,
   input wire logic [7:0] out_red,
   input wire logic [7:0] out_green,
   input wire logic [7:0] out_blue,
   input wire logic out_second,
   input wire logic [1:0] planar_layout,
   input wire logic [ADDR_W-1:0] luma_base,
   input wire logic [STRIDE_W-1:0] luma_stride,
   input wire logic [STRIDE_W-1:0] luma_rows,
   input wire logic [STRIDE_W-1:0] chroma_stride_in,
   input wire logic [STRIDE_W-1:0] chroma_stride_out,
   input wire logic [ADDR_W-1:0] u_base_out,
   input wire logic planar_error
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   sequence s_first_taken;
      out_valid && out_ready && !out_second;
   endsequence
   sequence s_second_same;
      out_valid && out_second && $stable(out_u) && $stable(out_v);
   endsequence
   ////////////////////////////////////////////////////////////////////////////
   AST_RGB_MAP: assert property (out_valid |-> out_red == out_v &&
      out_green == out_y && out_blue == out_u) else $error("colour channel map wrong");
   AST_PAIR: assert property (s_first_taken |=> s_second_same)
      else $error("second pixel missing or chroma changed");
   AST_HOLD: assert property (out_valid && !out_ready |=> out_valid &&
      $stable(out_y) && $stable(out_u) && $stable(out_v) && $stable(out_second))
      else $error("pixel changed while stalled");
   AST_LAT: assert property (in_valid && in_ready |-> ##[1:2] out_valid)
      else $error("no pixel after word taken");
   AST_S420: assert property (planar_layout == 2'h1 |=>
      chroma_stride_out == $past(luma_stride) >> 1) else $error("half stride wrong");
   AST_S410: assert property (planar_layout == 2'h2 |=>
      chroma_stride_out == $past(luma_stride) >> 2) else $error("quarter stride wrong");
   AST_UBASE: assert property (planar_layout inside {2'h1, 2'h2} |=>
      u_base_out == $past(luma_base) + $past(luma_stride) * $past(luma_rows))
      else $error("chroma plane not after luma");
   AST_INDEP: assert property (planar_layout == 2'h0 |=>
      chroma_stride_out == $past(chroma_stride_in)) else $error("chroma stride not kept");
   AST_RSVD: assert property (planar_layout == 2'h3 |=> planar_error)
      else $error("reserved layout not flagged");
endmodule : ysu_unpacker_chk
bind ysu_unpacker ysu_unpacker_chk #(.ADDR_W(ADDR_W), .STRIDE_W(STRIDE_W)) u_chk (
   .clock(clock), .rst_n(rst_n), .in_valid(in_valid), .in_ready(in_ready),
   .out_valid(out_valid), .out_ready(out_ready), .out_y(out_y), .out_u(out_u),
   .out_v(out_v), .out_red(out_red), .out_green(out_green), .out_blue(out_blue),
   .out_second(out_second), .planar_layout(planar_layout), .luma_base(luma_base),
   .luma_stride(luma_stride), .luma_rows(luma_rows), .chroma_stride_in(chroma_stride_in),
   .chroma_stride_out(chroma_stride_out), .u_base_out(u_base_out),
   .planar_error(planar_error));
`default_nettype wire

//--- ysu_unpacker_test.sv
`timescale 1ns/1ps
`default_nettype none
module ysu_unpacker_test;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic in_valid = 1'b0;
   logic stall = 1'b1;
   logic slow = 1'b0;
   logic [31:0] in_data = 32'h0;
   logic [1:0] in_order = 2'h0;
   logic [1:0] planar_layout = 2'h0;
   logic [31:0] luma_base = 32'h0, u_base_in = 32'h0, v_base_in = 32'h0;
   logic [15:0] luma_stride = 16'h0, luma_rows = 16'h0, chroma_stride_in = 16'h0;
   logic in_ready, out_valid, out_ready, out_second, planar_error;
   logic [7:0] out_y, out_u, out_v, out_red, out_green, out_blue;
   logic [31:0] luma_base_out, u_base_out, v_base_out;
   logic [15:0] luma_stride_out, chroma_stride_out;
   logic [24:0] exp_q[$];
   int n_fail = 0;
   int checks_done = 0;
   ysu_unpacker uut (.clock(clock), .rst_n(rst_n), .in_valid(in_valid), .in_ready(in_ready),
      .in_data(in_data), .in_order(in_order), .out_valid(out_valid), .out_ready(out_ready),
      .out_y(out_y), .out_u(out_u), .out_v(out_v), .out_red(out_red), .out_green(out_green),
      .out_blue(out_blue), .out_second(out_second), .planar_layout(planar_layout),
      .luma_base(luma_base), .luma_stride(luma_stride), .luma_rows(luma_rows),
      .chroma_stride_in(chroma_stride_in), .u_base_in(u_base_in), .v_base_in(v_base_in),
      .luma_base_out(luma_base_out), .luma_stride_out(luma_stride_out),
      .chroma_stride_out(chroma_stride_out), .u_base_out(u_base_out),
      .v_base_out(v_base_out), .planar_error(planar_error));
   ysu_sink sink (.clock(clock), .rst_n(rst_n), .stall(stall), .slow(slow),
      .out_valid(out_valid), .out_ready(out_ready), .out_y(out_y), .out_u(out_u),
      .out_v(out_v), .out_second(out_second));
   always #5 clock = ~clock;
   ////////////////////////////////////////////////////////////////////////////
   task end_sim;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : end_sim
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e)
      begin
         $display("ERROR %s expected %0h seen %0h", nm, e, g);
         n_fail++;
      end
   endtask : chk
   // Offers one word, holds it until taken
   task send(input logic [31:0] w, input logic [1:0] o);
      logic r;
      logic [7:0] y0, y1, u, v;
      case (o)
         2'h0: {v, y1, u, y0} = w;
         2'h1: {u, y1, v, y0} = w;
         2'h2: {y1, v, y0, u} = w;
         default: {y1, u, y0, v} = w;
      endcase
      exp_q.push_back({1'b0, y0, u, v});
      exp_q.push_back({1'b1, y1, u, v});
      in_valid = 1'b1;
      in_data = w;
      in_order = o;
      do
      begin
         r = in_ready;
         @(posedge clock);
         #1;
      end while (r !== 1'b1);
   endtask : send
   task drain;
      int n;
      n = 0;
      while (sink.got.size() < exp_q.size() && n < 500)
      begin
         @(posedge clock);
         n++;
      end
      repeat (5) @(posedge clock);
      #1;
      chk("pixel_count", exp_q.size(), sink.got.size());
      foreach (exp_q[i])
         if (i < sink.got.size())
            chk("pixel", exp_q[i], sink.got[i]);
      chk("out_valid_idle", 32'h0, out_valid);
      exp_q.delete();
      sink.got.delete();
   endtask : drain
   ////////////////////////////////////////////////////////////////////////////
   task t_orders;
      stall = 1'b0;
      slow = 1'b1;
      for (int o = 0; o < 4; o++)
         send(32'h4433_2211 + 32'(o), o[1:0]);
      send(32'hFF00_80FF, 2'h3);
      in_valid = 1'b0;
      drain;
   endtask : t_orders
   task t_full;
      stall = 1'b1;
      slow = 1'b0;
      for (int i = 0; i < 32; i++)
         send(32'hC0C1_C2C3 + 32'(i), 2'(i));
      in_data = 32'h0BAD_0BAD;
      repeat (3)
      begin
         @(posedge clock);
         #1;
         chk("in_ready_full", 32'h0, in_ready);
      end
      // Stalled on the first pixel of word C0C1C2C3: Y0 C3, U C2, V C0
      chk("out_red", 32'hC0, out_red);
      chk("out_green", 32'hC3, out_green);
      chk("out_blue", 32'hC2, out_blue);
      chk("out_second_stall", 32'h0, out_second);
      in_valid = 1'b0;
      stall = 1'b0;
      drain;
   endtask : t_full
   task t_planar;
      int sh;
      logic [31:0] ub, vb;
      logic [15:0] cs;
      luma_base = 32'h0001_0000;
      luma_stride = 16'h0280;
      luma_rows = 16'h01E0;
      chroma_stride_in = 16'h0100;
      u_base_in = 32'h0020_0000;
      v_base_in = 32'h0030_0000;
      for (int l = 0; l < 4; l++)
      begin
         planar_layout = l[1:0];
         repeat (2) @(posedge clock);
         #1;
         sh = (l == 1) ? 1 : (l == 2) ? 2 : 0;
         cs = sh != 0 ? luma_stride >> sh : chroma_stride_in;
         ub = sh != 0 ? luma_base + luma_stride * luma_rows : u_base_in;
         vb = sh != 0 ? ub + cs * (luma_rows >> sh) : v_base_in;
         chk("chroma_stride", cs, chroma_stride_out);
         chk("u_base", ub, u_base_out);
         chk("v_base", vb, v_base_out);
         chk("luma_stride", luma_stride, luma_stride_out);
         chk("luma_base", luma_base, luma_base_out);
         chk("planar_error", l == 3, planar_error);
      end
   endtask : t_planar
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      #50000;
      n_fail++;
      end_sim;
   end
   initial
   begin
      repeat (8) @(posedge clock);
      #1;
      chk("in_ready_rst", 32'h0, in_ready);
      rst_n = 1'b1;
      repeat (2) @(posedge clock);
      #1;
      t_orders;
      t_full;
      t_planar;
      end_sim;
   end
endmodule : ysu_unpacker_test
`default_nettype wire
